// ### hw/rpr_read_param.v
// Read-parameter register pair with set-parameter command decode
`timescale 1ns/1ps
`include "rpr_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module rpr_read_param (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire pwr_up_load_i,
  input wire link_sck_i,
  input wire link_cs_n_i,
  input wire [3:0] link_io_i,
  input wire quad_enable_bit_i,
  input wire quad_command_mode_i,
  input wire has_reset_pin_i,
  input wire reset_pin_disable_i,
  input wire [2:0] read_kind_i,
  output reg [7:0] nv_value_o,
  output reg [7:0] vol_value_o,
  output reg [3:0] dummy_cycles_o,
  output reg wrap_enable_o,
  output reg [6:0] wrap_bytes_o,
  output reg pin_hold_sel_o,
  output reg pin_reset_sel_o,
  output reg pin_data_line_3_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Dummy count: zero field selects the per-command default
  function [3:0] rpr_dummy;
    input [3:0] field;
    input [2:0] kind;
    begin
      if (field != 4'h0) begin
        rpr_dummy = field;
      end else begin
        // Kinds 6 and 7 are unused and take the single-lane default
        case (kind)
          `RPR_KIND_FAST_QPI: rpr_dummy = `RPR_DUMMY_DEF_QPI;
          `RPR_KIND_QUAD_IO: rpr_dummy = `RPR_DUMMY_DEF_QPI;
          `RPR_KIND_DUAL_IO: rpr_dummy = `RPR_DUMMY_DEF_DIO;
          default: rpr_dummy = `RPR_DUMMY_DEF_SPI;
        endcase
      end
    end
  endfunction

  // Wrap length in bytes from the burst field
  function [6:0] rpr_wrap_len;
    input [1:0] burst;
    begin
      case (burst)
        2'h0: rpr_wrap_len = `RPR_WRAP_8;
        2'h1: rpr_wrap_len = `RPR_WRAP_16;
        2'h2: rpr_wrap_len = `RPR_WRAP_32;
        default: rpr_wrap_len = `RPR_WRAP_64;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Link synchronisers; first stages feed only second stages
  reg sck_s1_r;
  reg sck_s2_r;
  reg sck_d_r;
  reg cs_s1_r;
  reg cs_s2_r;
  reg [3:0] io_s1_r;
  reg [3:0] io_s2_r;

  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_d_r <= 1'b0;
      // Chip select rests high so no frame opens during reset
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      io_s1_r <= 4'h0;
      io_s2_r <= 4'h0;
    end else begin
      sck_s1_r <= link_sck_i;
      sck_s2_r <= sck_s1_r;
      sck_d_r <= sck_s2_r;
      cs_s1_r <= link_cs_n_i;
      cs_s2_r <= cs_s1_r;
      io_s1_r <= link_io_i;
      io_s2_r <= io_s1_r;
    end
  end

  // Link clock idles low, so the reset values give no false edge
  wire sck_rise = sck_s2_r & ~sck_d_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame shifter: opcode then one data byte, extra bits ignored
  reg [15:0] shift_r;
  reg [15:0] shift_nxt;
  reg [4:0] bit_cnt_r;
  reg [4:0] bit_cnt_nxt;
  reg frame_done_r;
  reg frame_done_nxt;
  reg commit_nxt;

  always @* begin
    shift_nxt = shift_r;
    bit_cnt_nxt = bit_cnt_r;
    frame_done_nxt = frame_done_r;
    commit_nxt = 1'b0;
    // Chip select high ends the frame; late bits were already dropped
    if (cs_s2_r) begin
      bit_cnt_nxt = 5'h00;
      frame_done_nxt = 1'b0;
    end else if (sck_rise && !frame_done_r) begin
      // Quad command mode moves four bits per clock on all lines
      if (quad_command_mode_i) begin
        shift_nxt = {shift_r[11:0], io_s2_r};
        bit_cnt_nxt = bit_cnt_r + `RPR_BITS_QUAD;
      end else begin
        shift_nxt = {shift_r[14:0], io_s2_r[0]};
        bit_cnt_nxt = bit_cnt_r + `RPR_BITS_SERIAL;
      end
      // Short frames never reach the full count and commit nothing
      if (bit_cnt_nxt == `RPR_BITS_FRAME) begin
        frame_done_nxt = 1'b1;
        commit_nxt = 1'b1;
      end
    end
  end

  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      shift_r <= 16'h0000;
      bit_cnt_r <= 5'h00;
      frame_done_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      frame_done_r <= frame_done_nxt;
    end
  end

  wire [7:0] cmd_op = shift_nxt[15:8];
  wire [7:0] cmd_data = shift_nxt[7:0];
  // Any other opcode is dropped without effect
  wire op_is_nv = (cmd_op == `RPR_CMD_SET_NV);
  wire op_is_vol_a = (cmd_op == `RPR_CMD_SET_V_A);
  wire op_is_vol_b = (cmd_op == `RPR_CMD_SET_V_B);
  wire wr_nv = commit_nxt & op_is_nv;
  wire wr_vol = commit_nxt & (op_is_vol_a | op_is_vol_b);

  ////////////////////////////////////////////////////////////////////////////////
  // Register pair; reset stands for the shipped state, power-up reload is separate
  reg [7:0] nv_r;
  reg [7:0] vol_r;
  reg load_pend_r;

  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      nv_r <= `RPR_RESET_VAL;
      vol_r <= `RPR_RESET_VAL;
      // First edge after reset replays the power-up reload
      load_pend_r <= 1'b1;
    end else begin
      load_pend_r <= 1'b0;
      if (wr_nv) begin
        nv_r <= cmd_data;
      end
      // Host write in the load cycle wins so it is not lost
      if (wr_vol) begin
        vol_r <= cmd_data;
      end else if (load_pend_r || pwr_up_load_i) begin
        vol_r <= nv_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Settings seen by the read path from the volatile copy; data line 3 comes from the quad inputs alone
  wire [3:0] dummy_field = vol_r[`RPR_DUMMY_HI:`RPR_DUMMY_LO];
  wire [1:0] burst_field = vol_r[`RPR_BURST_HI:`RPR_BURST_LO];
  wire quad_pin = quad_enable_bit_i | quad_command_mode_i;
  wire reset_pin_live = has_reset_pin_i & ~reset_pin_disable_i;
  wire sel_reset = ~quad_pin & ~reset_pin_live & vol_r[`RPR_PIN_FUNC_BIT];

  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      nv_value_o <= `RPR_RESET_VAL;
      vol_value_o <= `RPR_RESET_VAL;
      dummy_cycles_o <= `RPR_DUMMY_DEF_SPI;
      wrap_enable_o <= 1'b0;
      wrap_bytes_o <= `RPR_WRAP_8;
      pin_hold_sel_o <= 1'b1;
      pin_reset_sel_o <= 1'b0;
      pin_data_line_3_o <= 1'b0;
    end else begin
      nv_value_o <= nv_r;
      vol_value_o <= vol_r;
      dummy_cycles_o <= rpr_dummy(dummy_field, read_kind_i);
      wrap_enable_o <= vol_r[`RPR_WRAP_EN_BIT];
      wrap_bytes_o <= rpr_wrap_len(burst_field);
      // Hold is the fallback when neither reset nor data line 3 applies
      pin_data_line_3_o <= quad_pin;
      pin_reset_sel_o <= sel_reset;
      pin_hold_sel_o <= ~quad_pin & ~sel_reset;
    end
  end

endmodule // rpr_read_param

// ### hw/rpr_defines.vh
// Constants for the read-parameter register block
`ifndef RPR_DEFINES_VH
`define RPR_DEFINES_VH
`define RPR_RESET_VAL 8'h00
`define RPR_CMD_SET_NV 8'h65
`define RPR_CMD_SET_V_A 8'hC0
`define RPR_CMD_SET_V_B 8'h63
`define RPR_PIN_FUNC_BIT 7
`define RPR_DUMMY_HI 6
`define RPR_DUMMY_LO 3
`define RPR_WRAP_EN_BIT 2
`define RPR_BURST_HI 1
`define RPR_BURST_LO 0
`define RPR_DUMMY_DEF_SPI 4'h8
`define RPR_DUMMY_DEF_QPI 4'h6
`define RPR_DUMMY_DEF_DIO 4'h4
`define RPR_KIND_FAST_SPI 3'h0
`define RPR_KIND_FAST_QPI 3'h1
`define RPR_KIND_DUAL_OUT 3'h2
`define RPR_KIND_DUAL_IO 3'h3
`define RPR_KIND_QUAD_OUT 3'h4
`define RPR_KIND_QUAD_IO 3'h5
`define RPR_WRAP_8 7'h08
`define RPR_WRAP_16 7'h10
`define RPR_WRAP_32 7'h20
`define RPR_WRAP_64 7'h40
`define RPR_BITS_OPCODE 5'h08
`define RPR_BITS_FRAME 5'h10
`define RPR_BITS_QUAD 5'h04
`define RPR_BITS_SERIAL 5'h01
`endif

// ### dv/rpr_host.sv
// Host link driver model
`timescale 1ns/1ps
module rpr_host (
  output logic sck_o = 1'b0,
  output logic cs_n_o = 1'b1,
  output logic [3:0] io_o = 4'h0
);
  // 8 MHz link clock; 60/65 ns halves keep every edge on a bench falling edge
  task automatic send(input logic [15:0] f, input logic q);
    cs_n_o = 1'b0;
    for (int i = 0; i < (q ? 4 : 16); i++) begin
      io_o = q ? f[15 - 4 * i -: 4] : {{3{~f[15 - i]}}, f[15 - i]};
      #60 sck_o = 1'b1;
      #65 sck_o = 1'b0;
    end
    #60 cs_n_o = 1'b1;
    io_o = ~io_o;
    #100;
  endtask
endmodule // rpr_host

// ### dv/rpr_read_param_properties.sv
// Port checker for the read-parameter register
`timescale 1ns/1ps
module rpr_props (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire pwr_up_load_i,
  input wire quad_enable_bit_i,
  input wire quad_command_mode_i,
  input wire has_reset_pin_i,
  input wire reset_pin_disable_i,
  input wire [2:0] read_kind_i,
  input wire [7:0] nv_value_o,
  input wire [7:0] vol_value_o,
  input wire [3:0] dummy_cycles_o,
  input wire wrap_enable_o,
  input wire [6:0] wrap_bytes_o,
  input wire pin_hold_sel_o,
  input wire pin_reset_sel_o,
  input wire pin_data_line_3_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  wire [7:0] v = vol_value_o;
  sequence s_load; pwr_up_load_i [*3]; endsequence
  property p_load; s_load |-> v == nv_value_o; endproperty
  property p_wb; wrap_bytes_o == 7'h08 << v[1:0]; endproperty
  property p_wen; wrap_enable_o == v[2]; endproperty
  property p_fld; v[6:3] != 4'h0 |-> dummy_cycles_o == v[6:3]; endproperty
  property p_def; v[6:3] == 4'h0 |-> dummy_cycles_o == ($past(read_kind_i) == 3'h3 ? 4'h4 :
    $past(read_kind_i) inside {3'h1, 3'h5} ? 4'h6 : 4'h8); endproperty
  property p_dl3; pin_data_line_3_o == ($past(quad_enable_bit_i) | $past(quad_command_mode_i));
  endproperty
  property p_rst; pin_reset_sel_o == (v[7] & !pin_data_line_3_o & !($past(has_reset_pin_i) &
    !$past(reset_pin_disable_i))); endproperty
  property p_hold; pin_hold_sel_o == !(pin_reset_sel_o | pin_data_line_3_o); endproperty
  a_load: assert property (p_load) else $error("load");
  a_wb: assert property (p_wb) else $error("wrap size");
  a_wen: assert property (p_wen) else $error("wrap en");
  a_fld: assert property (p_fld) else $error("dummy");
  a_def: assert property (p_def) else $error("dummy def");
  a_dl3: assert property (p_dl3) else $error("line 3");
  a_rst: assert property (p_rst) else $error("reset sel");
  a_hold: assert property (p_hold) else $error("hold sel");
endmodule // rpr_props
bind rpr_read_param rpr_props u_props (
  .sys_clk_i(sys_clk_i),
  .nrst_i(nrst_i),
  .pwr_up_load_i(pwr_up_load_i),
  .quad_enable_bit_i(quad_enable_bit_i),
  .quad_command_mode_i(quad_command_mode_i),
  .has_reset_pin_i(has_reset_pin_i),
  .reset_pin_disable_i(reset_pin_disable_i),
  .read_kind_i(read_kind_i),
  .nv_value_o(nv_value_o),
  .vol_value_o(vol_value_o),
  .dummy_cycles_o(dummy_cycles_o),
  .wrap_enable_o(wrap_enable_o),
  .wrap_bytes_o(wrap_bytes_o),
  .pin_hold_sel_o(pin_hold_sel_o),
  .pin_reset_sel_o(pin_reset_sel_o),
  .pin_data_line_3_o(pin_data_line_3_o)
);

// ### dv/rpr_read_param_test.sv
// Bench for the read-parameter register block
`timescale 1ns/1ps
`include "rpr_defines.vh"
module rpr_read_param_test;
  logic clk = 1'b0, nrst = 1'b0, pul = 1'b0, qe = 1'b0, qcm = 1'b0, hrp = 1'b0, rpd = 1'b0;
  logic sck, cs_n, wen, hold, rsel, dl3;
  logic [2:0] kind = 3'h0;
  logic [3:0] io, dum;
  logic [7:0] nv, vol;
  logic [6:0] wb;
  logic [23:0] dflt = 24'h684868;
  int err_total = 0, checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  rpr_host u_host (.sck_o(sck), .cs_n_o(cs_n), .io_o(io));
  rpr_read_param u_dut (.sys_clk_i(clk), .nrst_i(nrst), .pwr_up_load_i(pul), .link_sck_i(sck),
    .link_cs_n_i(cs_n), .link_io_i(io), .quad_enable_bit_i(qe), .quad_command_mode_i(qcm),
    .has_reset_pin_i(hrp), .reset_pin_disable_i(rpd), .read_kind_i(kind), .nv_value_o(nv),
    .vol_value_o(vol), .dummy_cycles_o(dum), .wrap_enable_o(wen), .wrap_bytes_o(wb),
    .pin_hold_sel_o(hold), .pin_reset_sel_o(rsel), .pin_data_line_3_o(dl3));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic test_done;
    if (err_total == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    u_host.send({op, d}, qcm);
    @(negedge clk);
  endtask
  task automatic pn(input logic [3:0] e);
    repeat (2) @(negedge clk);
    chk({4'h0, hold, rsel, dl3, wen}, {4'h0, e});
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    pn(4'h8);
    chk({nv, vol}, 16'h0000);
    chk({4'h0, dum}, 8'h08);
    chk({1'b0, wb}, 8'h08);
    wr(`RPR_CMD_SET_NV, 8'hA9);
    wr(8'h12, 8'h5A);
    chk(nv, 8'hA9);
    chk(vol, 8'h00);
    pul = 1'b1;
    repeat (3) @(negedge clk);
    pul = 1'b0;
    pn(4'h4);
    chk(vol, 8'hA9);
    chk({4'h0, dum}, 8'h05);
    qcm = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(`RPR_CMD_SET_V_A, 8'h04 | i[7:0]);
      chk({1'b0, wb}, 8'h08 << i);
    end
    pn(4'h3);
    chk(nv, 8'hA9);
    for (int k = 0; k < 6; k++) begin
      kind = k[2:0];
      repeat (2) @(negedge clk);
      chk({4'h0, dum}, {4'h0, dflt[4 * k +: 4]});
    end
    qcm = 1'b0;
    hrp = 1'b1;
    wr(`RPR_CMD_SET_V_B, 8'h80);
    pn(4'h8);
    rpd = 1'b1;
    pn(4'h4);
    qe = 1'b1;
    pn(4'h2);
    test_done();
  end
endmodule // rpr_read_param_test
